// file: design/alarm_defs.svh
// constants for the two-channel process alarm block
// assumes a 25 MHz reference clock and a 32-bit classic wishbone bus
`ifndef ALARM_DEFS_SVH
`define ALARM_DEFS_SVH
// timing
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 40
`define TICK_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define MENU_TIMEOUT_S 4'hA
`define DELAY_MAX_S 12'hE10
// register byte offsets
`define ACCESS_OFS 8'h00
`define STATUS_OFS 8'h04
`define CH_BASE(c) (8'h10 + 8'h10 * (c))
`define CTRL_OFS 8'h00
`define SETPOINT_OFS 8'h04
`define HYST_OFS 8'h08
`define TIMES_OFS 8'h0C
// field positions and reset values
`define CTRL_TOTAL_BIT 1
`define ACC_CODE_LSB 16
`define TIMES_SIL_LSB 16
`define CODE_DEFAULT 16'h0000
`define CODE_LAST_POS 3'h3
`endif

// file: design/alarm_pkg.sv
// types shared by the alarm channel design
// assumes alarm_defs.svh supplies all numeric constants
package alarm_pkg;
    typedef enum logic [1:0] {
        A_IDLE = 2'b00,
        A_DELAY = 2'b01,
        A_ACTIVE = 2'b10,
        A_SILENCED = 2'b11
    } alarm_state_t;
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_CODE_PROMPT = 3'b001,
        M_CODE_ENTRY = 3'b010,
        M_SP_PROMPT = 3'b011,
        M_SP_EDIT = 3'b100
    } menu_state_t;
    // per-channel control bits, bit 0 is enable
    typedef struct packed {
        logic flash;
        logic nc;
        logic low;
        logic total;
        logic enable;
    } chan_cfg_t;
    // front panel push buttons, high while held
    typedef struct packed {
        logic prog;
        logic up;
        logic down;
        logic enter;
    } btn_t;
endpackage

// file: design/process_alarm_channel.sv
// two independent alarm channels of a flow rate totaliser, plus the
// front-panel setpoint access menu, behind a classic wishbone slave
// assumes buttons and process values are synchronous to i_ref_clk
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "alarm_defs.svh"
module process_alarm_channel import alarm_pkg::*; #(
    parameter int CHANNELS = 2,
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // process values and front panel
    input wire logic [31:0] i_rate_value,
    input wire logic [31:0] i_total_value,
    input wire logic i_total_mode,
    input wire btn_t i_buttons,
    // alarm contacts and display
    output logic [CHANNELS-1:0] o_alarm_closed,
    output logic [CHANNELS-1:0] o_annunciator,
    output logic [CHANNELS-1:0] o_show_label,
    output menu_state_t o_menu_view,
    output logic o_menu_sel,
    output logic o_prompt_total,
    output logic [31:0] o_edit_value,
    output logic [2:0] o_edit_pos
);
    // byte-lane merge of a write into an old register value
    function automatic logic [31:0] wb_merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (old & ~m) | (d & m);
    endfunction

    // step one hex digit of an entry value up or down, wrapping
    function automatic logic [31:0] nib_step(input logic [31:0] v,
        input logic [2:0] p, input logic up);
        logic [31:0] r;
        logic [3:0] n;
        r = v;
        n = v[{p, 2'b00} +: 4];
        r[{p, 2'b00} +: 4] = up ? n + 4'h1 : n - 4'h1;
        return r;
    endfunction

    logic [31:0] rd_data_reg;
    logic ack_reg;
    logic bus_wr;
    logic bus_rd;
    logic [24:0] tick_cnt_reg;
    logic tick_reg;
    logic blink_reg;
    btn_t btn_d_reg;
    btn_t pr;
    logic menu_en_reg;
    logic [15:0] code_pend_reg;
    logic [15:0] code_act_reg;
    menu_state_t menu_reg;
    logic sel_reg;
    logic [31:0] edit_reg;
    logic [2:0] pos_reg;
    logic [3:0] idle_secs_reg;
    logic prompt_total_reg;
    logic accept;
    logic sp_store;
    logic combo_open;
    logic [31:0] acc_w;
    chan_cfg_t cfg_reg [CHANNELS];
    logic [31:0] sp_reg [CHANNELS];
    logic [31:0] hyst_reg [CHANNELS];
    logic [11:0] delay_reg [CHANNELS];
    logic [15:0] sil_reg [CHANNELS];
    alarm_state_t state_reg [CHANNELS];
    logic [CHANNELS-1:0] cond_reg;
    logic [CHANNELS-1:0] closed_reg;
    logic [CHANNELS-1:0] annun_reg;
    logic [CHANNELS-1:0] label_reg;

    assign bus_wr = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_reg;
    assign bus_rd = i_wb_cyc & i_wb_stb & ~ack_reg;
    assign pr = i_buttons & ~btn_d_reg;
    // prog as accept only outside the menu and not as part of the combo
    assign accept = pr.prog & ~i_buttons.up & (menu_reg == M_IDLE);
    assign sp_store = (menu_reg == M_SP_EDIT) & pr.enter;
    assign combo_open = i_buttons.prog & i_buttons.up & (pr.prog | pr.up)
        & menu_en_reg & i_total_mode & (menu_reg == M_IDLE);
    // access word after a byte-lane write, split into its fields below
    assign acc_w = wb_merge({code_pend_reg, 15'h0, menu_en_reg}, i_wb_dat,
        i_wb_sel);

    // one second tick and a blink phase that toggles on every tick
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            tick_cnt_reg <= 25'h0;
            tick_reg <= 1'b0;
            blink_reg <= 1'b0;
        end else if (tick_cnt_reg == 25'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 25'h0;
            tick_reg <= 1'b1;
            blink_reg <= ~blink_reg;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 25'h1;
            tick_reg <= 1'b0;
        end
    end

    // wishbone answer: ack one cycle after the strobe, dropped next cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ack_reg <= 1'b0;
            rd_data_reg <= 32'h0;
        end else begin
            ack_reg <= bus_rd;
            if (bus_rd) begin
                rd_data_reg <= 32'h0;
                if (i_wb_adr == `ACCESS_OFS)
                    rd_data_reg <= {code_pend_reg, 15'h0, menu_en_reg};
                if (i_wb_adr == `STATUS_OFS) begin
                    rd_data_reg[10:8] <= menu_reg;
                    rd_data_reg[11] <= sel_reg;
                    for (int c = 0; c < CHANNELS; c++) begin
                        rd_data_reg[c*4 +: 4] <=
                            {cond_reg[c], closed_reg[c], state_reg[c]};
                    end
                end
                for (int c = 0; c < CHANNELS; c++) begin
                    if (i_wb_adr == `CH_BASE(c) + `CTRL_OFS)
                        rd_data_reg <= {27'h0, cfg_reg[c]};
                    if (i_wb_adr == `CH_BASE(c) + `SETPOINT_OFS)
                        rd_data_reg <= sp_reg[c];
                    if (i_wb_adr == `CH_BASE(c) + `HYST_OFS)
                        rd_data_reg <= hyst_reg[c];
                    if (i_wb_adr == `CH_BASE(c) + `TIMES_OFS)
                        rd_data_reg <= {sil_reg[c], 4'h0, delay_reg[c]};
                end
            end
        end
    end

    // access menu settings; pending code goes live in total mode only
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            menu_en_reg <= 1'b0;
            code_pend_reg <= `CODE_DEFAULT;
            code_act_reg <= `CODE_DEFAULT;
        end else begin
            if (bus_wr && i_wb_adr == `ACCESS_OFS) begin
                code_pend_reg <= acc_w[31:`ACC_CODE_LSB];
                menu_en_reg <= acc_w[0];
            end
            if (i_total_mode && menu_reg == M_IDLE)
                code_act_reg <= code_pend_reg;
        end
    end

    // setpoint access menu
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            btn_d_reg <= '0;
            menu_reg <= M_IDLE;
            sel_reg <= 1'b0;
            edit_reg <= 32'h0;
            pos_reg <= 3'h0;
            idle_secs_reg <= 4'h0;
            prompt_total_reg <= 1'b0;
        end else begin
            btn_d_reg <= i_buttons;
            prompt_total_reg <= cfg_reg[sel_reg].total;
            if (menu_reg == M_IDLE || (|pr))
                idle_secs_reg <= 4'h0;
            else if (tick_reg)
                idle_secs_reg <= idle_secs_reg + 4'h1;
            unique case (menu_reg)
                M_IDLE: begin
                    if (combo_open) begin
                        sel_reg <= 1'b0;
                        menu_reg <= (code_act_reg == `CODE_DEFAULT) ?
                            M_SP_PROMPT : M_CODE_PROMPT;
                    end
                end
                M_CODE_PROMPT: begin
                    if (pr.prog) begin
                        edit_reg <= 32'h0;
                        pos_reg <= 3'h0;
                        menu_reg <= M_CODE_ENTRY;
                    end
                end
                M_CODE_ENTRY: begin
                    if (pr.up || pr.down)
                        edit_reg <= nib_step(edit_reg, pos_reg, pr.up);
                    else if (pr.prog)
                        pos_reg <= (pos_reg == `CODE_LAST_POS) ?
                            3'h0 : pos_reg + 3'h1;
                    else if (pr.enter)
                        menu_reg <= (edit_reg[15:0] == code_act_reg) ?
                            M_SP_PROMPT : M_IDLE;
                end
                M_SP_PROMPT: begin
                    if (pr.up || pr.down)
                        sel_reg <= ~sel_reg;
                    else if (pr.prog) begin
                        edit_reg <= sp_reg[sel_reg];
                        pos_reg <= 3'h0;
                        menu_reg <= M_SP_EDIT;
                    end else if (pr.enter)
                        menu_reg <= M_IDLE;
                end
                M_SP_EDIT: begin
                    if (pr.up || pr.down)
                        edit_reg <= nib_step(edit_reg, pos_reg, pr.up);
                    else if (pr.prog)
                        pos_reg <= pos_reg + 3'h1;
                    else if (pr.enter)
                        menu_reg <= M_SP_PROMPT;
                end
                default: menu_reg <= M_IDLE;
            endcase
            // inactivity timeout, blocked by any new press, so it never overrides a step above
            if (menu_reg != M_IDLE && !(|pr) && tick_reg &&
                idle_secs_reg + 4'h1 >= `MENU_TIMEOUT_S)
                menu_reg <= M_IDLE;
        end
    end

    generate
        for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
            logic [31:0] ctrl_w;
            logic [31:0] times_w;
            logic [31:0] val;
            logic [32:0] hy;
            logic set_c;
            logic clr_c;
            logic [15:0] cnt_reg;
            assign ctrl_w = wb_merge({27'h0, cfg_reg[g]}, i_wb_dat,
                i_wb_sel);
            assign times_w = wb_merge({sil_reg[g], 4'h0, delay_reg[g]},
                i_wb_dat, i_wb_sel);
            assign val = cfg_reg[g].total ? i_total_value : i_rate_value;
            assign hy = cfg_reg[g].total ? 33'h0 : {1'b0, hyst_reg[g]};
            assign set_c = cfg_reg[g].low ? (val <= sp_reg[g])
                : (val >= sp_reg[g]);
            assign clr_c = cfg_reg[g].low ?
                ({1'b0, val} > {1'b0, sp_reg[g]} + hy) :
                ({1'b0, val} + hy < {1'b0, sp_reg[g]});

            // channel settings from bus and from the access menu
            always_ff @(posedge i_ref_clk) begin
                if (i_srst) begin
                    cfg_reg[g] <= '0;
                    sp_reg[g] <= 32'h0;
                    hyst_reg[g] <= 32'h0;
                    delay_reg[g] <= 12'h0;
                    sil_reg[g] <= 16'h0;
                end else begin
                    if (sp_store && sel_reg == g[0])
                        sp_reg[g] <= edit_reg;
                    if (bus_wr && i_wb_adr == `CH_BASE(g) + `SETPOINT_OFS)
                        sp_reg[g] <= wb_merge(sp_reg[g], i_wb_dat,
                            i_wb_sel);
                    if (bus_wr && i_wb_adr == `CH_BASE(g) + `HYST_OFS &&
                        !cfg_reg[g].total)
                        hyst_reg[g] <= wb_merge(hyst_reg[g], i_wb_dat,
                            i_wb_sel);
                    if (bus_wr && i_wb_adr == `CH_BASE(g) + `TIMES_OFS) begin
                        sil_reg[g] <= times_w[31:`TIMES_SIL_LSB];
                        delay_reg[g] <= (times_w[15:0] >
                            {4'h0, `DELAY_MAX_S}) ? `DELAY_MAX_S :
                            times_w[11:0];
                    end
                    if (bus_wr && i_wb_adr == `CH_BASE(g) + `CTRL_OFS) begin
                        cfg_reg[g] <= chan_cfg_t'(ctrl_w[4:0]);
                        if (ctrl_w[`CTRL_TOTAL_BIT] != cfg_reg[g].total)
                        begin
                            cfg_reg[g] <= '0;
                            cfg_reg[g].total <= ctrl_w[`CTRL_TOTAL_BIT];
                            sp_reg[g] <= 32'h0;
                            hyst_reg[g] <= 32'h0;
                            delay_reg[g] <= 12'h0;
                            sil_reg[g] <= 16'h0;
                        end
                    end
                end
            end

            // alarm condition with hysteresis, then delay/silence sequencer
            always_ff @(posedge i_ref_clk) begin
                if (i_srst) begin
                    cond_reg[g] <= 1'b0;
                    state_reg[g] <= A_IDLE;
                    cnt_reg <= 16'h0;
                end else begin
                    cond_reg[g] <= cond_reg[g] ? ~clr_c : set_c;
                    unique case (state_reg[g])
                        A_IDLE: begin
                            cnt_reg <= 16'h0;
                            if (cfg_reg[g].enable && cond_reg[g])
                                state_reg[g] <= (delay_reg[g] == 12'h0) ?
                                    A_ACTIVE : A_DELAY;
                        end
                        A_DELAY: begin
                            if (!cfg_reg[g].enable || !cond_reg[g])
                                state_reg[g] <= A_IDLE;
                            else if (tick_reg) begin
                                cnt_reg <= 16'(cnt_reg + 16'h1);
                                if (16'(cnt_reg + 16'h1) >=
                                    {4'h0, delay_reg[g]})
                                    state_reg[g] <= A_ACTIVE;
                            end
                        end
                        A_ACTIVE: begin
                            cnt_reg <= 16'h0;
                            if (!cfg_reg[g].enable || !cond_reg[g])
                                state_reg[g] <= A_IDLE;
                            else if (accept && sil_reg[g] != 16'h0)
                                state_reg[g] <= A_SILENCED;
                        end
                        A_SILENCED: begin
                            if (!cfg_reg[g].enable)
                                state_reg[g] <= A_IDLE;
                            else if (tick_reg) begin
                                cnt_reg <= 16'(cnt_reg + 16'h1);
                                if (16'(cnt_reg + 16'h1) >= sil_reg[g])
                                    state_reg[g] <= A_IDLE;
                            end
                        end
                    endcase
                end
            end

            // contact, annunciator and label drive, all registered
            always_ff @(posedge i_ref_clk) begin
                if (i_srst) begin
                    closed_reg[g] <= 1'b0;
                    annun_reg[g] <= 1'b0;
                    label_reg[g] <= 1'b0;
                end else begin
                    closed_reg[g] <= (state_reg[g] == A_ACTIVE) ^
                        cfg_reg[g].nc;
                    annun_reg[g] <= (state_reg[g] == A_ACTIVE) ||
                        (blink_reg && state_reg[g] != A_IDLE);
                    label_reg[g] <= (state_reg[g] == A_ACTIVE) &&
                        cfg_reg[g].flash && blink_reg;
                end
            end

            sequence s_accept;
                state_reg[g] == A_ACTIVE && accept && sil_reg[g] != 16'h0;
            endsequence
            hyst_total_a: assert property (@(posedge i_ref_clk)
                disable iff (i_srst) cfg_reg[g].total |-> hyst_reg[g] == 0)
                else $error("total alarm holds hysteresis");
            high_set_a: assert property (@(posedge i_ref_clk)
                disable iff (i_srst) !cond_reg[g] && !cfg_reg[g].low &&
                val >= sp_reg[g] |=> cond_reg[g])
                else $error("high alarm not raised");
            zero_delay_a: assert property (@(posedge i_ref_clk)
                disable iff (i_srst) state_reg[g] == A_IDLE &&
                cfg_reg[g].enable && cond_reg[g] && delay_reg[g] == 0
                |=> state_reg[g] == A_ACTIVE)
                else $error("zero delay not immediate");
            steady_lamp_a: assert property (@(posedge i_ref_clk)
                disable iff (i_srst) state_reg[g] == A_ACTIVE
                |=> annun_reg[g] && closed_reg[g] != cfg_reg[g].nc)
                else $error("active alarm not driven");
            accept_gate_a: assert property (@(posedge i_ref_clk)
                disable iff (i_srst) state_reg[g] == A_ACTIVE &&
                sil_reg[g] == 0 |=> state_reg[g] != A_SILENCED)
                else $error("accept with zero silence");
            silence_out_a: assert property (@(posedge i_ref_clk)
                disable iff (i_srst) s_accept ##1 state_reg[g] == A_SILENCED
                |=> closed_reg[g] == cfg_reg[g].nc)
                else $error("silenced output not released");
            type_reset_a: assert property (@(posedge i_ref_clk)
                disable iff (i_srst) bus_wr &&
                i_wb_adr == `CH_BASE(g) + `CTRL_OFS &&
                ctrl_w[`CTRL_TOTAL_BIT] != cfg_reg[g].total
                |=> !cfg_reg[g].enable && sp_reg[g] == 0)
                else $error("type change kept settings");
        end
    endgenerate

    code_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !i_total_mode |=> $stable(code_act_reg))
        else $error("code applied outside total mode");
    no_code_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        combo_open && code_act_reg == 0 |=> menu_reg == M_SP_PROMPT)
        else $error("zero code still prompted");

    assign o_wb_dat = rd_data_reg;
    assign o_wb_ack = ack_reg;
    assign o_alarm_closed = closed_reg;
    assign o_annunciator = annun_reg;
    assign o_show_label = label_reg;
    assign o_menu_view = menu_reg;
    assign o_menu_sel = sel_reg;
    assign o_prompt_total = prompt_total_reg;
    assign o_edit_value = edit_reg;
    assign o_edit_pos = pos_reg;
endmodule

// file: sim/field_sounder.sv
// field sounder switched by one alarm contact
// assumes the contact sense follows the channel's nc setting
`timescale 1ns/100ps
module field_sounder (
    // contact and its configured sense
    input wire logic i_closed,
    input wire logic i_nc,
    // audible output
    output logic o_sounding
);
    // nc contacts open on alarm, so sound on the opposite level
    assign o_sounding = i_closed ^ i_nc;
endmodule

// file: sim/process_alarm_channel_bench.sv
// self-checking bench for the alarm channel block
// assumes a ten-cycle tick so seconds pass quickly
`timescale 1ns/100ps
`include "alarm_defs.svh"
module process_alarm_channel_bench import alarm_pkg::*;;
    localparam logic [7:0] c0 = `CH_BASE(0);
    localparam logic [7:0] c1 = `CH_BASE(1);
    logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, tmode = 0, ncfg = 0;
    logic [7:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] dat = '0, rate = '0, tot = '0, rdat, sp;
    btn_t btn = '0;
    logic ack, msel, ptot, snd;
    logic [31:0] edit;
    logic [2:0] epos;
    logic [1:0] closed, ann, lbl;
    menu_state_t view;
    logic [31:0] q[$];
    int fails = 0, samples_checked = 0, hits;
    always #20 clk = ~clk;
    process_alarm_channel #(.CHANNELS(2), .TICK_CYCLES(10)) dut_u (
        .i_ref_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_rate_value(rate),
        .i_total_value(tot), .i_total_mode(tmode), .i_buttons(btn),
        .o_alarm_closed(closed), .o_annunciator(ann), .o_show_label(lbl),
        .o_menu_view(view), .o_menu_sel(msel), .o_prompt_total(ptot),
        .o_edit_value(edit), .o_edit_pos(epos));
    field_sounder snd_u (.i_closed(closed[0]), .i_nc(ncfg), .o_sounding(snd));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // read data against the oldest note, taken at the acked edge
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0)
            chk(rdat, q.pop_front());
    // one classic cycle; held until ack is seen, then released
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        // no limit here: only the watchdog ends a wait
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    // hold buttons for one cycle, then let the menu settle
    task automatic press(input btn_t b);
        @(posedge clk);
        btn <= b;
        @(posedge clk);
        btn <= '0;
        repeat (4) @(posedge clk);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic conclude();
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, well past the expected run of under a thousand cycles
    initial begin
        wt(4000);
        fails++;
        conclude();
    end
    initial begin
        void'($urandom(10));
        sp = 32'h100 + ($urandom % 32'h100);
        wt(8);
        srst <= 0;
        rd(c0 + `CTRL_OFS, 32'h0);
        wr(8'hF0, 32'hFFFFFFFF);
        rd(8'hF0, 32'h0);
        wr(c0 + `SETPOINT_OFS, sp);
        wr(c0 + `HYST_OFS, 32'h10);
        wr(c0 + `CTRL_OFS, 32'h01);
        rate <= sp;
        wt(5);
        chk({29'h0, snd, ann[0], closed[0]}, 32'h7);
        chk({28'h0, lbl, ann[1], closed[1]}, 32'h0);
        press(4'b1000);
        chk({31'h0, closed[0]}, 32'h1);
        rate <= sp - 32'h10;
        wt(5);
        chk({31'h0, closed[0]}, 32'h1);
        rate <= sp - 32'h11;
        wt(5);
        chk({29'h0, snd, ann[0], closed[0]}, 32'h0);
        ncfg <= 1;
        wr(c0 + `CTRL_OFS, 32'h09);
        wt(3);
        chk({30'h0, snd, closed[0]}, 32'h1);
        ncfg <= 0;
        wr(c0 + `CTRL_OFS, 32'h11);
        wr(c0 + `TIMES_OFS, 32'h00030002);
        rate <= sp;
        wt(5);
        chk({31'h0, closed[0]}, 32'h0);
        wt(32);
        chk({30'h0, ann[0], closed[0]}, 32'h3);
        hits = 0;
        // label alternates with the value while the output is active
        for (int i = 0; i < 25; i++) begin
            wt(1);
            hits += int'(lbl[0]);
        end
        chk({31'h0, hits > 0 && hits < 25}, 32'h1);
        press(4'b1000);
        hits = 0;
        // lamp blinks while the silence time runs
        for (int i = 0; i < 14; i++) begin
            wt(1);
            hits += int'(ann[0]);
        end
        chk({31'h0, hits > 0 && hits < 14}, 32'h1);
        chk({31'h0, closed[0]}, 32'h0);
        wt(70);
        chk({31'h0, closed[0]}, 32'h1);
        rate <= 32'h0;
        // low alarm on channel 0, no delay, hysteresis still 0x10
        wr(c0 + `TIMES_OFS, 32'h0);
        wr(c0 + `CTRL_OFS, 32'h05);
        wt(5);
        chk({31'h0, closed[0]}, 32'h1);
        rate <= sp + 32'h10;
        wt(5);
        chk({31'h0, closed[0]}, 32'h1);
        rate <= sp + 32'h11;
        wt(5);
        chk({31'h0, closed[0]}, 32'h0);
        wr(c1 + `SETPOINT_OFS, 32'h7);
        wr(c1 + `CTRL_OFS, 32'h03);
        rd(c1 + `SETPOINT_OFS, 32'h0);
        rd(c1 + `CTRL_OFS, 32'h02);
        wr(c1 + `HYST_OFS, 32'h5);
        rd(c1 + `HYST_OFS, 32'h0);
        wr(c1 + `TIMES_OFS, 32'hFFF);
        rd(c1 + `TIMES_OFS, 32'hE10);
        tmode <= 1;
        press(4'b1100);
        chk(32'(view), 32'(M_IDLE));
        wr(`ACCESS_OFS, 32'h1);
        press(4'b1100);
        chk(32'(view), 32'(M_SP_PROMPT));
        press(4'b0010);
        chk({30'h0, msel, ptot}, 32'h3);
        press(4'b1000);
        press(4'b0100);
        chk(edit, 32'h1);
        press(4'b1000);
        chk({29'h0, epos}, 32'h1);
        press(4'b0010);
        chk(edit, 32'hF1);
        press(4'b0001);
        rd(c1 + `SETPOINT_OFS, 32'hF1);
        press(4'b0001);
        chk(32'(view), 32'(M_IDLE));
        wr(`ACCESS_OFS, 32'h00010001);
        wt(2);
        press(4'b1100);
        chk(32'(view), 32'(M_CODE_PROMPT));
        press(4'b1000);
        press(4'b0001);
        chk(32'(view), 32'(M_IDLE));
        press(4'b1100);
        press(4'b1000);
        press(4'b0100);
        press(4'b0001);
        chk(32'(view), 32'(M_SP_PROMPT));
        wt(125);
        chk(32'(view), 32'(M_IDLE));
        conclude();
    end
endmodule
